//--- logic/drive_select_params.svh
`ifndef DRIVE_SELECT_PARAMS_SVH
`define DRIVE_SELECT_PARAMS_SVH

// register indices; byte address is four times the index
`define MOTOR_CTRL_IDX 6'h02
`define TAPE_IDX       6'h03
`define CFG_IDX        6'h05
`define STAT_IDX       6'h06

// drive_motor_control fields
`define CTRL_NUM_LSB   0
`define CTRL_RST_BIT   2
`define CTRL_DMA_BIT   3
`define CTRL_MOT_LSB   4
`define CTRL_RESET     8'h00

// tape_assignment fields
`define TAPE_RESET     2'h0

// config_reg_five fields
`define CFG_EXT_BIT    0
`define CFG_SWAP_BIT   1
`define CFG_RESET      2'h0

// axi responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

//--- logic/drive_select_pkg.sv
package drive_select_pkg;

	typedef logic [7:0]  reg8_t;
	typedef logic [31:0] word_t;

	typedef struct packed
	{
		logic        aw_have;
		logic [7:0]  aw_addr;
		logic        w_have;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		word_t       rdata;
		reg8_t       motor_ctrl;
		logic [1:0]  tape_sel;
		logic [1:0]  cfg;
		logic        ctrl_wr;
		logic        tape_wr;
		logic [1:0]  pick_low;
		logic [1:0]  motor_low;
		logic [3:0]  motor_on;
		logic        tape_active;
		logic        reset_low;
		logic        dma_en;
	} state_s;

endpackage

//--- logic/drive_decode.sv
`timescale 1ns/100ps

module drive_decode
	import drive_select_pkg::*;
(
	input  wire logic [1:0] drive_num,
	input  wire logic [3:0] mot_en,
	input  wire logic       external_decoder_select,
	input  wire logic       swap,
	output logic      [1:0] pick_low,
	output logic      [1:0] motor_low
);
	logic [1:0] code;
	logic       sel_en;

	always_comb
	begin
		code      = drive_num;
		sel_en    = mot_en[drive_num];
		pick_low  = 2'h3;
		motor_low = 2'h3;
		if (external_decoder_select)
		begin
			// external 2-to-4 decoder sits on the pick lines
			if (swap && !drive_num[1])
				code = {1'b0, ~drive_num[0]};
			pick_low  = code;
			motor_low = {1'b1, ~sel_en};
		end
		else if (!swap)
		begin
			// only drives 0 and 1 reachable here
			pick_low[0] = !(drive_num == 2'h0 && mot_en[0]);
			pick_low[1] = !(drive_num == 2'h1 && mot_en[1]);
			motor_low   = {~mot_en[1], ~mot_en[0]};
		end
		else
		begin
			pick_low[1] = !(drive_num == 2'h0 && mot_en[0]);
			pick_low[0] = !(drive_num == 2'h1 && mot_en[1]);
			motor_low   = {~mot_en[0], ~mot_en[1]};
		end
	end

endmodule

//--- logic/floppy_drive_select_decode.sv
`timescale 1ns/100ps
`include "drive_select_params.svh"

module floppy_drive_select_decode
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire drive_select_pkg::word_t  s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic [2:0]               s_axi_arprot,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output drive_select_pkg::word_t       s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic                          drive_pick_low0,
	output logic                          drive_pick_low1,
	output logic                          motor_on_low0,
	output logic                          motor_on_low1,
	output logic                          motor_on_out0,
	output logic                          motor_on_out1,
	output logic                          motor_on_out2,
	output logic                          motor_on_out3,
	output logic                          tape_mode_active,
	output logic                          fdc_reset_low,
	output logic                          dma_enable
);
	import drive_select_pkg::*;

	state_s     st_q;
	state_s     st_d;
	logic [1:0] dec_pick_low;
	logic [1:0] dec_motor_low;

	// register index from a byte address; low two bits ignored
	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		reg_index = addr[7:2];
	endfunction

	function automatic logic reg_mapped(input logic [5:0] idx);
		reg_mapped = (idx == `MOTOR_CTRL_IDX) || (idx == `TAPE_IDX) ||
			(idx == `CFG_IDX) || (idx == `STAT_IDX);
	endfunction

	// field picks of the control register; shared by decode, tape match and checks
	function automatic logic [1:0] drive_number(input reg8_t ctrl);
		drive_number = ctrl[`CTRL_NUM_LSB +: 2];
	endfunction

	function automatic logic [3:0] motor_bits(input reg8_t ctrl);
		motor_bits = ctrl[`CTRL_MOT_LSB +: 4];
	endfunction

	drive_decode drive_decode_inst
	(
		.drive_num               (drive_number(st_q.motor_ctrl)),
		.mot_en                  (motor_bits(st_q.motor_ctrl)),
		.external_decoder_select (st_q.cfg[`CFG_EXT_BIT]),
		.swap                    (st_q.cfg[`CFG_SWAP_BIT]),
		.pick_low                (dec_pick_low),
		.motor_low               (dec_motor_low)
	);

	always_comb
	begin
		logic       aw_hs;
		logic       w_hs;
		logic       ar_hs;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic       wr_lane;
		logic [5:0] wr_idx;
		logic [5:0] rd_idx;
		aw_hs   = s_axi_awvalid && st_q.awready;
		w_hs    = s_axi_wvalid && st_q.wready;
		ar_hs   = s_axi_arvalid && st_q.arready;
		wr_addr = aw_hs ? s_axi_awaddr : st_q.aw_addr;
		wr_data = w_hs ? s_axi_wdata[7:0] : st_q.w_data;
		wr_lane = w_hs ? s_axi_wstrb[0] : st_q.w_lane0;
		wr_idx  = reg_index(wr_addr);
		rd_idx  = reg_index(s_axi_araddr);
		st_d    = st_q;
		st_d.ctrl_wr = 1'b0;
		st_d.tape_wr = 1'b0;

		// write channel: address and data taken in either order
		if (aw_hs)
		begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (w_hs)
		begin
			st_d.w_have  = 1'b1;
			st_d.w_data  = s_axi_wdata[7:0];
			st_d.w_lane0 = s_axi_wstrb[0];
		end
		if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;
		if (st_d.aw_have && st_d.w_have && !st_q.bvalid)
		begin
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = reg_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
			// registers live in byte lane 0 only
			if (wr_lane)
			begin
				unique case (wr_idx)
					`MOTOR_CTRL_IDX:
					begin
						st_d.motor_ctrl = wr_data;
						st_d.ctrl_wr    = 1'b1;
					end
					`TAPE_IDX:
					begin
						st_d.tape_sel = wr_data[1:0];
						st_d.tape_wr  = 1'b1;
					end
					`CFG_IDX:
						st_d.cfg = wr_data[1:0];
					default:
						st_d.cfg = st_d.cfg;
				endcase
			end
		end
		// ready held low while a response is pending
		st_d.awready = !st_d.aw_have && !st_d.bvalid;
		st_d.wready  = !st_d.w_have && !st_d.bvalid;

		// read channel
		if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
		if (ar_hs)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = reg_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
			st_d.rdata  = '0;
			unique case (rd_idx)
				`MOTOR_CTRL_IDX:
					st_d.rdata[7:0] = st_q.motor_ctrl;
				`TAPE_IDX:
					st_d.rdata[1:0] = st_q.tape_sel;
				`CFG_IDX:
					st_d.rdata[1:0] = st_q.cfg;
				`STAT_IDX:
					st_d.rdata[8:0] = {st_q.tape_active, st_q.motor_on,
						st_q.motor_low, st_q.pick_low};
				default:
					st_d.rdata = '0;
			endcase
		end
		st_d.arready = !st_d.rvalid;

		// pin outputs registered once more so the decode never glitches
		st_d.pick_low  = dec_pick_low;
		st_d.motor_low = dec_motor_low;
		st_d.motor_on  = motor_bits(st_q.motor_ctrl);
		// tape drive 0 is unreachable: code 00 means none
		st_d.tape_active = (st_q.tape_sel != 2'h0) &&
			(drive_number(st_q.motor_ctrl) == st_q.tape_sel);
		st_d.reset_low = st_q.motor_ctrl[`CTRL_RST_BIT];
		st_d.dma_en    = st_q.motor_ctrl[`CTRL_DMA_BIT];
	end

	// the software reset only drives fdc_reset_low; no register here obeys it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q             <= '0;
			st_q.motor_ctrl  <= `CTRL_RESET;
			st_q.tape_sel    <= `TAPE_RESET;
			st_q.cfg         <= `CFG_RESET;
			st_q.pick_low    <= 2'h3;
			st_q.motor_low   <= 2'h3;
			st_q.awready     <= 1'b1;
			st_q.wready      <= 1'b1;
			st_q.arready     <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign s_axi_awready    = st_q.awready;
	assign s_axi_wready     = st_q.wready;
	assign s_axi_bresp      = st_q.bresp;
	assign s_axi_bvalid     = st_q.bvalid;
	assign s_axi_arready    = st_q.arready;
	assign s_axi_rdata      = st_q.rdata;
	assign s_axi_rresp      = st_q.rresp;
	assign s_axi_rvalid     = st_q.rvalid;
	assign drive_pick_low0  = st_q.pick_low[0];
	assign drive_pick_low1  = st_q.pick_low[1];
	assign motor_on_low0    = st_q.motor_low[0];
	assign motor_on_low1    = st_q.motor_low[1];
	assign motor_on_out0    = st_q.motor_on[0];
	assign motor_on_out1    = st_q.motor_on[1];
	assign motor_on_out2    = st_q.motor_on[2];
	assign motor_on_out3    = st_q.motor_on[3];
	assign tape_mode_active = st_q.tape_active;
	assign fdc_reset_low    = st_q.reset_low;
	assign dma_enable       = st_q.dma_en;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic       ext_q;
	logic       swp_q;
	logic [1:0] num_q;
	logic [3:0] en_q;
	assign ext_q = st_q.cfg[`CFG_EXT_BIT];
	assign swp_q = st_q.cfg[`CFG_SWAP_BIT];
	assign num_q = drive_number(st_q.motor_ctrl);
	assign en_q  = motor_bits(st_q.motor_ctrl);

	sequence ctrl_write_s;
		st_q.ctrl_wr;
	endsequence

	sequence outputs_follow_s;
		##1 ({motor_on_out3, motor_on_out2, motor_on_out1, motor_on_out0} == $past(en_q)) &&
			(fdc_reset_low == $past(st_q.motor_ctrl[`CTRL_RST_BIT]));
	endsequence

	motor_zero_a: assert property (motor_on_out0 == $past(en_q[0]))
		else $error("motor output 0 does not follow enable bit 4");
	motor_one_a: assert property (motor_on_out1 == $past(en_q[1]))
		else $error("motor output 1 does not follow enable bit 5");
	motor_two_a: assert property (motor_on_out2 == $past(en_q[2]))
		else $error("motor output 2 does not follow enable bit 6");
	motor_three_a: assert property (motor_on_out3 == $past(en_q[3]))
		else $error("motor output 3 does not follow enable bit 7");

	write_follow_a: assert property (ctrl_write_s |-> outputs_follow_s)
		else $error("outputs did not follow a control write");

	one_pick_a: assert property (!ext_q |=> !(!drive_pick_low0 && !drive_pick_low1))
		else $error("two drives picked at once");

	int_high_a: assert property (!ext_q && (num_q[1] || en_q == 4'h0)
		|=> drive_pick_low0 && drive_pick_low1)
		else $error("internal mode pick asserted for drive 2 or 3");

	int_plain_a: assert property (!ext_q && !swp_q |=>
		drive_pick_low0 == !($past(num_q) == 2'h0 && $past(en_q[0])) &&
		motor_on_low1 == !$past(en_q[1]))
		else $error("internal unswapped decode wrong");

	int_swap_a: assert property (!ext_q && swp_q |=>
		drive_pick_low1 == !($past(num_q) == 2'h0 && $past(en_q[0])) &&
		motor_on_low0 == !$past(en_q[1]))
		else $error("internal swapped decode wrong");

	ext_plain_a: assert property (ext_q && !swp_q |=>
		{drive_pick_low1, drive_pick_low0} == $past(num_q) && motor_on_low1 &&
		motor_on_low0 == !$past(en_q[num_q]))
		else $error("external unswapped decode wrong");

	ext_swap_a: assert property (ext_q && swp_q && num_q[1] == 1'b0 |=>
		{drive_pick_low1, drive_pick_low0} == {1'b0, !$past(num_q[0])})
		else $error("external swapped code wrong");

	tape_pick_a: assert property (tape_mode_active |->
		$past(st_q.tape_sel) != 2'h0 && $past(num_q) == $past(st_q.tape_sel))
		else $error("tape mode on for a drive not assigned");

	// a host write may still change it; only the software reset must not
	tape_keep_a: assert property (!st_q.reset_low |=> st_q.tape_wr || $stable(st_q.tape_sel))
		else $error("tape register changed during software reset");

	tape_zero_a: assert property (tape_mode_active |-> $past(num_q) != 2'h0)
		else $error("tape mode on for the boot drive");

	tape_on_a: assert property (st_q.tape_sel != 2'h0 && num_q == st_q.tape_sel |=> tape_mode_active)
		else $error("tape mode missing for the assigned drive");

	int_plain_one_a: assert property (!ext_q && !swp_q |=>
		drive_pick_low1 == !($past(num_q) == 2'h1 && $past(en_q[1])) &&
		motor_on_low0 == !$past(en_q[0]))
		else $error("internal unswapped decode of drive 1 wrong");

	int_swap_one_a: assert property (!ext_q && swp_q |=>
		drive_pick_low0 == !($past(num_q) == 2'h1 && $past(en_q[1])) &&
		motor_on_low1 == !$past(en_q[0]))
		else $error("internal swapped decode of drive 1 wrong");

	ext_swap_motor_a: assert property (ext_q && swp_q |=>
		motor_on_low1 && motor_on_low0 == !$past(en_q[num_q]))
		else $error("external swapped motor outputs wrong");

	pin_steady_a: assert property ($stable(st_q.motor_ctrl) && $stable(st_q.cfg) |=>
		$stable({drive_pick_low1, drive_pick_low0, motor_on_low1, motor_on_low0}))
		else $error("pin outputs changed without a register change");

	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel ready while a response is pending");

	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address ready while read data is pending");

	tape_read_a: assert property (s_axi_arvalid && s_axi_arready &&
		reg_index(s_axi_araddr) == `TAPE_IDX |=> s_axi_rdata[31:2] == 30'h0)
		else $error("tape register upper bits not zero");

	write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid)
		else $error("write response missing one cycle after address and data");

	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response missing one cycle after address");

endmodule

//--- tb/drive_cable_model.sv
`timescale 1ns/100ps

module drive_cable_model
(
	input  wire logic       ext_mode,
	input  wire logic       drive_pick_low0,
	input  wire logic       drive_pick_low1,
	output logic      [2:0] picked,
	output logic            conflict
);
	// external mode feeds a 2-to-4 decoder, so the two pins are a code, not selects
	always_comb
	begin
		conflict = 1'b0;
		if (ext_mode)
			picked = {1'b0, drive_pick_low1, drive_pick_low0};
		else
		begin
			picked   = !drive_pick_low0 ? 3'h0 : !drive_pick_low1 ? 3'h1 : 3'h7;
			conflict = !drive_pick_low0 && !drive_pick_low1;
		end
	end
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps

module tb;
	import drive_select_pkg::*;
	logic       aclk          = 1'b0;
	logic       aresetn       = 1'b0;
	logic [7:0] s_axi_awaddr  = 8'h00;
	logic [2:0] s_axi_awprot  = 3'h0;
	logic       s_axi_awvalid = 1'b0;
	word_t      s_axi_wdata   = 32'h0;
	logic [3:0] s_axi_wstrb   = 4'hf;
	logic       s_axi_wvalid  = 1'b0;
	logic       s_axi_bready  = 1'b0;
	logic [7:0] s_axi_araddr  = 8'h00;
	logic [2:0] s_axi_arprot  = 3'h0;
	logic       s_axi_arvalid = 1'b0;
	logic       s_axi_rready  = 1'b0;
	logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	word_t      s_axi_rdata;
	logic       drive_pick_low0, drive_pick_low1, motor_on_low0, motor_on_low1;
	logic       motor_on_out0, motor_on_out1, motor_on_out2, motor_on_out3;
	logic       tape_mode_active, fdc_reset_low, dma_enable, conflict;
	logic [2:0] picked;
	logic [1:0] cfg_now       = 2'h0;
	int         failures      = 0;
	int         total_checks  = 0;
	logic [7:0] acts [6]      = '{8'h1c, 8'h2d, 8'h4e, 8'h8f, 8'h2c, 8'h0d};

	always #10 aclk = ~aclk;

	floppy_drive_select_decode floppy_drive_select_decode_inst
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_pick_low0,
		.drive_pick_low1, .motor_on_low0, .motor_on_low1, .motor_on_out0, .motor_on_out1,
		.motor_on_out2, .motor_on_out3, .tape_mode_active, .fdc_reset_low, .dma_enable
	);

	drive_cable_model drive_cable_model_inst
	(
		.ext_mode(cfg_now[0]), .drive_pick_low0, .drive_pick_low1, .picked, .conflict
	);

	task automatic print_verdict;
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input word_t got, input word_t exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// leading edge keeps a release and the next request out of one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, r});
	endtask

	task automatic rd(input logic [7:0] a, input word_t d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, d);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask

	// pins are sampled mid-cycle so the update edge has settled
	task automatic pins(input logic [7:0] v, input logic [1:0] t);
		logic [1:0] n;
		logic       e;
		logic [1:0] s;
		logic [3:0] x;
		logic [2:0] k;
		n = v[1:0];
		e = v[4 + n];
		s = (cfg_now[1] && !n[1]) ? n ^ 2'h1 : n;
		if (cfg_now[0])
			x = {s, 1'b1, !e};
		else
			x = {!(e && s == 2'h1 && !n[1]), !(e && s == 2'h0 && !n[1]),
				cfg_now[1] ? {!v[4], !v[5]} : {!v[5], !v[4]}};
		// cable sees a drive code in external mode, one live line or none internally
		k = (cfg_now[0] || (e && !n[1])) ? {1'b0, s} : 3'h7;
		@(negedge aclk);
		chk({17'h0, picked, motor_on_out3, motor_on_out2, motor_on_out1, motor_on_out0, fdc_reset_low,
			dma_enable, tape_mode_active, conflict, drive_pick_low1, drive_pick_low0,
			motor_on_low1, motor_on_low0},
			{17'h0, k, v[7:4], v[2], v[3], t != 2'h0 && n == t, 1'b0, x});
	endtask

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		pins(8'h00, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h0c, 32'h0, 2'h0);
		rd(8'h14, 32'h0, 2'h0);
		for (int c = 0; c < 4; c++)
		begin
			cfg_now = 2'(c);
			wr(8'h14, 8'(c), 2'h0);
			foreach (acts[i])
			begin
				wr(8'h08, acts[i], 2'h0);
				pins(acts[i], 2'h0);
			end
		end
		wr(8'h0c, 8'hff, 2'h0);
		rd(8'h0c, 32'h3, 2'h0);
		wr(8'h08, 8'h8f, 2'h0);
		pins(8'h8f, 2'h3);
		wr(8'h08, 8'h0b, 2'h0);
		rd(8'h0c, 32'h3, 2'h0);
		pins(8'h0b, 2'h3);
		wr(8'h0c, 8'h01, 2'h0);
		wr(8'h08, 8'h2d, 2'h0);
		pins(8'h2d, 2'h1);
		wr(8'h0c, 8'h00, 2'h0);
		wr(8'h08, 8'h1c, 2'h0);
		pins(8'h1c, 2'h0);
		wr(8'h20, 8'h55, 2'h2);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h18, 8'h00, 2'h0);
		pins(8'h1c, 2'h0);
		rd(8'h18, 32'h19, 2'h0);
		s_axi_wstrb <= 4'he;
		wr(8'h08, 8'h00, 2'h0);
		s_axi_wstrb <= 4'hf;
		pins(8'h1c, 2'h0);
		print_verdict;
	end

	initial
	begin
		repeat (4000) @(posedge aclk);
		failures++;
		print_verdict;
	end
endmodule
